// ===== timer_pkg.sv
// constants, field layout and bus carrier of the 16-bit timer core
// assumes one clock domain (bus clock) and a synchronous active-high reset
package timer_pkg;

   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [2:0] REG_STATUS_CONTROL = 3'h0;
   localparam logic [2:0] REG_COUNT_HIGH = 3'h1;
   localparam logic [2:0] REG_COUNT_LOW = 3'h2;
   localparam logic [2:0] REG_WRAP_HIGH = 3'h3;
   localparam logic [2:0] REG_WRAP_LOW = 3'h4;

   // ------------------------------------------------------------
   // status/control fields
   // ------------------------------------------------------------
   localparam int FLAG_BIT = 7;
   localparam int IRQ_EN_BIT = 6;
   localparam int CLK_SEL_LSB = 3;
   localparam int PRESCALE_LSB = 0;

   localparam logic [1:0] CLK_NONE = 2'h0;
   localparam logic [1:0] CLK_BUS = 2'h1;
   localparam logic [1:0] CLK_FIXED = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [1:0] CLK_SEL_RESET = 2'h0;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] WRAP_RESET = 16'h0000;
   localparam logic [15:0] FREE_RUN_TOP = 16'hFFFF;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ------------------------------------------------------------
   // bus carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

endpackage

// ===== clock_sync.sv
// two-flop synchroniser for the external timer clock and its rising edge
// assumes ext_clk is asynchronous to clk
module clock_sync
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin side
   input wire logic ext_clk,
   // core side
   output logic ext_tick
);

   logic meta;
   logic sync;
   logic sync_last;

   // ------------------------------------------------------------
   // synchroniser and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         sync_last <= 1'b0;
      end else begin
         meta <= ext_clk;
         sync <= meta;
         sync_last <= sync;
      end
   end

   assign ext_tick = sync & ~sync_last;

endmodule

// ===== prescaler.sv
// power-of-two divider of a tick stream, division 1 to 128
// assumes in_tick is a one-cycle pulse on clk
module prescaler
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire logic [2:0] prescale_select,
   // ticks
   input wire logic in_tick,
   output logic out_tick
);

   logic [6:0] div_count;
   logic [6:0] mask;

   // mask is read straight from the register, so a new factor acts next cycle
   assign mask = 7'((8'h01 << prescale_select) - 8'h01);
   assign out_tick = enable & in_tick & ((div_count & mask) == mask);

   // ------------------------------------------------------------
   // divider count
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         div_count <= 7'h00;
      end else if (in_tick) begin
         div_count <= div_count + 7'h01;
      end
   end

endmodule

// ===== timer_core.sv
// counter, modulo, overflow flag and register file of the 16-bit timer
// assumes a single-master byte bus on clk; debug mode is a level on clk
//
// Implementation choices: the address-and-strobe port and the register addresses.
module timer_core
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire bus_req_t bus,
   output logic [7:0] rdata,
   // clock sources
   input wire logic ext_clk,
   input wire logic fixed_clk_tick,
   input wire logic pll_active,
   // debug
   input wire logic background_debug_mode,
   // status out
   output logic overflow_irq,
   output logic [15:0] count_value
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic overflow_flag;
   logic overflow_irq_enable;
   logic [1:0] clock_source_select;
   logic [2:0] prescale_select;
   logic clear_armed;

   logic [15:0] count;
   logic [15:0] count_latch;
   logic latch_held;
   logic latch_first_low;

   logic [15:0] wrap_limit;
   logic [7:0] wrap_buf_high;
   logic [7:0] wrap_buf_low;
   logic wrap_high_done;
   logic wrap_low_done;

   logic ext_tick;
   logic source_tick;
   logic prescaled_tick;
   logic count_tick;
   logic [15:0] top;
   logic at_top;
   logic overflow_event;
   logic overflow_inhibit;
   logic wrap_pending;
   logic wrap_update_point;

   logic wr_sc;
   logic wr_cnt;
   logic wr_mod_h;
   logic wr_mod_l;
   logic rd_sc;
   logic rd_cnt_h;
   logic rd_cnt_l;
   logic latch_restart;
   logic [7:0] next_rdata;

   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   assign wr_sc = bus.wr && bus.addr == REG_STATUS_CONTROL;
   assign wr_cnt = bus.wr && (bus.addr == REG_COUNT_HIGH || bus.addr == REG_COUNT_LOW);
   assign wr_mod_h = bus.wr && bus.addr == REG_WRAP_HIGH;
   assign wr_mod_l = bus.wr && bus.addr == REG_WRAP_LOW;
   assign rd_sc = bus.rd && bus.addr == REG_STATUS_CONTROL;
   assign rd_cnt_h = bus.rd && bus.addr == REG_COUNT_HIGH;
   assign rd_cnt_l = bus.rd && bus.addr == REG_COUNT_LOW;

   // ------------------------------------------------------------
   // clock source selection
   // ------------------------------------------------------------
   clock_sync u_clock_sync (
      .clk(clk),
      .rst(rst),
      .ext_clk(ext_clk),
      .ext_tick(ext_tick)
   );

   always_comb begin
      unique case (clock_source_select)
         CLK_NONE: source_tick = 1'b0;
         CLK_BUS: source_tick = 1'b1;
         CLK_FIXED: source_tick = pll_active ? fixed_clk_tick : 1'b1;
         CLK_EXT: source_tick = ext_tick;
      endcase
   end

   prescaler u_prescaler (
      .clk(clk),
      .rst(rst),
      .enable(clock_source_select != CLK_NONE),
      .prescale_select(prescale_select),
      .in_tick(source_tick),
      .out_tick(prescaled_tick)
   );

   // counting stops in debug mode and with no source selected
   assign count_tick = prescaled_tick & ~background_debug_mode;

   // ------------------------------------------------------------
   // wrap and overflow conditions
   // ------------------------------------------------------------
   // modulo zero means free running over the whole range
   assign top = (wrap_limit == WRAP_RESET) ? FREE_RUN_TOP : wrap_limit;
   assign at_top = count == top;
   assign overflow_event = count_tick && at_top && !wr_cnt;
   assign overflow_inhibit = wrap_high_done ^ wrap_low_done;
   assign wrap_pending = wrap_high_done & wrap_low_done;
   assign wrap_update_point = count_tick && !wr_cnt && count == top - 16'h0001;

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= COUNT_RESET;
      end else if (wr_cnt) begin
         count <= COUNT_RESET;
      end else if (count_tick) begin
         if (at_top) begin
            count <= COUNT_RESET;
         end else begin
            count <= count + 16'h0001;
         end
      end
   end

   assign count_value = count;

   // ------------------------------------------------------------
   // status and control register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         overflow_irq_enable <= 1'b0;
         clock_source_select <= CLK_SEL_RESET;
         prescale_select <= PRESCALE_RESET;
      end else if (wr_sc) begin
         overflow_irq_enable <= bus.wdata[IRQ_EN_BIT];
         clock_source_select <= bus.wdata[CLK_SEL_LSB +: 2];
         prescale_select <= bus.wdata[PRESCALE_LSB +: 3];
      end
   end

   // ------------------------------------------------------------
   // overflow flag and its clearing sequence
   // ------------------------------------------------------------
   // a read while set arms the clear; a fresh overflow disarms it
   always_ff @(posedge clk) begin
      if (rst) begin
         clear_armed <= 1'b0;
      end else if (overflow_event && !overflow_inhibit) begin
         clear_armed <= 1'b0;
      end else if (rd_sc && overflow_flag) begin
         clear_armed <= 1'b1;
      end else if (wr_sc) begin
         clear_armed <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         overflow_flag <= 1'b0;
      end else if (overflow_event && !overflow_inhibit) begin
         overflow_flag <= 1'b1;
      end else if (wr_sc && clear_armed && !bus.wdata[FLAG_BIT]) begin
         overflow_flag <= 1'b0;
      end
   end

   assign overflow_irq = overflow_flag & overflow_irq_enable;

   // ------------------------------------------------------------
   // counter read coherency latch
   // ------------------------------------------------------------
   assign latch_restart = wr_sc || wr_cnt;

   always_ff @(posedge clk) begin
      if (rst) begin
         latch_held <= 1'b0;
         latch_first_low <= 1'b0;
         count_latch <= COUNT_RESET;
      end else if (latch_restart) begin
         latch_held <= 1'b0;
      end else if (background_debug_mode) begin
         latch_held <= latch_held;
      end else if (rd_cnt_h || rd_cnt_l) begin
         if (!latch_held) begin
            latch_held <= 1'b1;
            latch_first_low <= rd_cnt_l;
            count_latch <= count;
         end else if (latch_first_low == rd_cnt_h) begin
            latch_held <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // modulo buffer and active modulo
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         wrap_high_done <= 1'b0;
         wrap_low_done <= 1'b0;
         wrap_buf_high <= WRAP_RESET[15:8];
         wrap_buf_low <= WRAP_RESET[7:0];
      end else if (wr_sc) begin
         wrap_high_done <= 1'b0;
         wrap_low_done <= 1'b0;
      end else if (background_debug_mode) begin
         wrap_high_done <= wrap_high_done;
      end else if (wrap_pending && (clock_source_select == CLK_NONE || wrap_update_point)) begin
         wrap_high_done <= 1'b0;
         wrap_low_done <= 1'b0;
      end else begin
         if (wr_mod_h) begin
            wrap_buf_high <= bus.wdata;
            wrap_high_done <= 1'b1;
         end
         if (wr_mod_l) begin
            wrap_buf_low <= bus.wdata;
            wrap_low_done <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrap_limit <= WRAP_RESET;
      end else if (background_debug_mode) begin
         if (wr_mod_h) begin
            wrap_limit[15:8] <= bus.wdata;
         end
         if (wr_mod_l) begin
            wrap_limit[7:0] <= bus.wdata;
         end
      end else if (!wr_sc && wrap_pending) begin
         if (clock_source_select == CLK_NONE || wrap_update_point) begin
            wrap_limit <= {wrap_buf_high, wrap_buf_low};
         end
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = UNMAPPED_READ;
      unique case (bus.addr)
         REG_STATUS_CONTROL: begin
            next_rdata[FLAG_BIT] = overflow_flag;
            next_rdata[IRQ_EN_BIT] = overflow_irq_enable;
            next_rdata[CLK_SEL_LSB +: 2] = clock_source_select;
            next_rdata[PRESCALE_LSB +: 3] = prescale_select;
         end
         REG_COUNT_HIGH: next_rdata = latch_held ? count_latch[15:8] : count[15:8];
         REG_COUNT_LOW: next_rdata = latch_held ? count_latch[7:0] : count[7:0];
         REG_WRAP_HIGH: next_rdata = wrap_limit[15:8];
         REG_WRAP_LOW: next_rdata = wrap_limit[7:0];
         default: next_rdata = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= UNMAPPED_READ;
      end else if (bus.rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= UNMAPPED_READ;
      end
   end

endmodule

// ===== timer_checker.sv
// concurrent checks on the timer core ports
// assumes a bind onto timer_core, single clock, sync reset
module timer_checker
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire bus_req_t bus,
   input wire logic [7:0] rdata,
   input wire logic pll_active,
   input wire logic background_debug_mode,
   input wire logic overflow_irq,
   input wire logic [15:0] count_value
);
   // ------------------------------------------------------------
   // shadow of control and modulo writes
   // ------------------------------------------------------------
   logic [7:0] sc;
   logic [2:0] run;
   logic [2:0] idle;
   logic [1:0] pend;
   logic [1:0] mbit;
   logic cnt_wr;
   logic sc_wr;
   logic mw;
   logic step_ok;
   assign cnt_wr = bus.wr && (bus.addr == REG_COUNT_HIGH || bus.addr == REG_COUNT_LOW);
   assign sc_wr = bus.wr && bus.addr == REG_STATUS_CONTROL;
   assign mw = bus.wr && !background_debug_mode &&
      (bus.addr == REG_WRAP_HIGH || bus.addr == REG_WRAP_LOW);
   assign mbit = (bus.addr == REG_WRAP_HIGH) ? 2'h2 : 2'h1;
   assign step_ok = !bus.wr && !background_debug_mode && sc[2:0] == 3'h0 &&
      (sc[4:3] == CLK_BUS || (sc[4:3] == CLK_FIXED && !pll_active));
   always_ff @(posedge clk)
      if (rst) sc <= 8'h00;
      else if (sc_wr) sc <= bus.wdata;
   always_ff @(posedge clk)
      if (rst || !step_ok) run <= 3'h0;
      else if (run != 3'h7) run <= run + 3'h1;
   always_ff @(posedge clk)
      if (rst || sc[4:3] != CLK_NONE || cnt_wr) idle <= 3'h0;
      else if (idle != 3'h7) idle <= idle + 3'h1;
   always_ff @(posedge clk)
      if (rst || sc_wr) pend <= 2'h0;
      else if (mw && (pend | mbit) == 2'h3) pend <= 2'h0;
      else if (mw) pend <= pend | mbit;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      !$past(bus.rd) |-> rdata == 8'h00) else $error("read data outside slot");
   a_count_clear: assert property (@(posedge clk) disable iff (rst)
      cnt_wr |=> count_value == COUNT_RESET) else $error("count write did not clear");
   a_bus_step: assert property (@(posedge clk) disable iff (rst)
      run == 3'h7 && step_ok |=> count_value == $past(count_value) + 16'h0001 ||
      count_value == 16'h0000) else $error("bus rate count step wrong");
   a_hold_none: assert property (@(posedge clk) disable iff (rst)
      idle == 3'h7 && !cnt_wr |=> $stable(count_value)) else $error("count moved unclocked");
   a_debug_freeze: assert property (@(posedge clk) disable iff (rst)
      background_debug_mode && $past(background_debug_mode) && $past(background_debug_mode, 2)
      && !cnt_wr |=> $stable(count_value)) else $error("count moved in debug");
   a_irq_enable: assert property (@(posedge clk) disable iff (rst)
      !sc[6] |-> !overflow_irq) else $error("irq without enable");
   a_irq_sticky: assert property (@(posedge clk) disable iff (rst)
      overflow_irq && !sc_wr |=> overflow_irq) else $error("flag lost without write");
   a_wrap_flag: assert property (@(posedge clk) disable iff (rst)
      (!cnt_wr && count_value != 16'h0000 ##1 count_value == 16'h0000 && sc[6] &&
      pend == 2'h0 && !bus.wr) |-> ##[0:1] overflow_irq) else $error("wrap without flag");
   a_pend_quiet: assert property (@(posedge clk) disable iff (rst)
      pend != 2'h0 && $past(pend) != 2'h0 && $past(pend, 2) != 2'h0 && !$past(overflow_irq)
      && !$past(bus.wr) |-> !overflow_irq) else $error("flag set with modulo pending");
endmodule

bind timer_core timer_checker chk (
   .clk(clk),
   .rst(rst),
   .bus(bus),
   .rdata(rdata),
   .pll_active(pll_active),
   .background_debug_mode(background_debug_mode),
   .overflow_irq(overflow_irq),
   .count_value(count_value)
);

// ===== testbench.sv
// self-checking bench for the timer core
// assumes the port checker is bound inside timer_core
module testbench
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   bus_req_t bus = '0;
   logic [7:0] rdata;
   logic ext_clk = 1'b0;
   logic fixed_clk_tick = 1'b0;
   logic pll_active = 1'b1;
   logic background_debug_mode = 1'b0;
   logic overflow_irq;
   logic [15:0] count_value;
   int bad_count = 0;
   int checks_done = 0;
   int seed = 32'hED07762C;
   int n;
   int m;
   int m2;
   always #5 clk = ~clk;
   timer_core dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .ext_clk(ext_clk),
      .fixed_clk_tick(fixed_clk_tick), .pll_active(pll_active),
      .background_debug_mode(background_debug_mode), .overflow_irq(overflow_irq),
      .count_value(count_value));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] ctl(input logic en, input logic [1:0] sel, input int ps);
      return {1'b0, en, 1'b0, sel, 3'(ps)};
   endfunction
   function automatic logic [15:0] after(input int ticks, input int top);
      return 16'(ticks % (top + 1));
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 check({8'h00, rdata}, {8'h00, exp});
   endtask
   task automatic edges(input int k);
      repeat (k) begin
         @(posedge clk);
         ext_clk <= 1'b1;
         repeat (3) @(posedge clk);
         ext_clk <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge clk);
         fixed_clk_tick <= 1'b1;
         @(posedge clk);
         fixed_clk_tick <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(REG_STATUS_CONTROL, 8'h00);
      rc(REG_WRAP_HIGH, 8'h00);
      rc(REG_WRAP_LOW, 8'h00);
      rc(3'h5, UNMAPPED_READ);
      check(count_value, COUNT_RESET);
      repeat (10) @(posedge clk);
      wr(REG_STATUS_CONTROL, ctl(1'b0, CLK_FIXED, 0));
      wr(REG_COUNT_HIGH, 8'($random(seed)));
      n = $random(seed) & 15;
      ticks(n);
      check(count_value, after(n, 65535));
      pll_active <= 1'b0;
      repeat (12) @(posedge clk);
      pll_active <= 1'b1;
      wr(REG_STATUS_CONTROL, ctl(1'b0, CLK_BUS, 0));
      repeat (12) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         wr(REG_STATUS_CONTROL, ctl(1'b0, CLK_EXT, k));
         wr(REG_COUNT_LOW, 8'h00);
         edges(4 << k);
         check(count_value, after(4, 65535));
      end
      // counter read coherency
      wr(REG_STATUS_CONTROL, ctl(1'b0, CLK_EXT, 0));
      wr(REG_COUNT_LOW, 8'h00);
      edges(254);
      rc(REG_COUNT_LOW, 8'hFE);
      edges(4);
      rc(REG_COUNT_HIGH, 8'h00);
      rc(REG_COUNT_HIGH, 8'h01);
      rc(REG_COUNT_LOW, 8'h02);
      rc(REG_COUNT_LOW, 8'h02);
      wr(REG_COUNT_HIGH, 8'($random(seed)));
      rc(REG_COUNT_HIGH, 8'h00);
      rc(REG_COUNT_LOW, 8'h00);
      rc(REG_COUNT_LOW, 8'h00);
      edges(256);
      wr(REG_STATUS_CONTROL, ctl(1'b0, CLK_EXT, 0));
      rc(REG_COUNT_HIGH, 8'h01);
      rc(REG_COUNT_LOW, 8'h00);
      // modulo, overflow flag and its clearing
      m = 8 + ($random(seed) & 15);
      wr(REG_STATUS_CONTROL, ctl(1'b0, CLK_NONE, 0));
      wr(REG_COUNT_LOW, 8'h00);
      wr(REG_WRAP_HIGH, 8'h00);
      wr(REG_WRAP_LOW, 8'(m));
      wr(REG_STATUS_CONTROL, ctl(1'b1, CLK_EXT, 0));
      edges(m);
      check(16'(overflow_irq), 16'h0000);
      edges(1);
      check(count_value, after(m + 1, m));
      check(16'(overflow_irq), 16'h0001);
      // flag settles after the write edge, so look one step later
      wr(REG_STATUS_CONTROL, ctl(1'b1, CLK_EXT, 0));
      #1 check(16'(overflow_irq), 16'h0001);
      rc(REG_STATUS_CONTROL, 8'h80 | ctl(1'b1, CLK_EXT, 0));
      wr(REG_STATUS_CONTROL, ctl(1'b1, CLK_EXT, 0));
      #1 check(16'(overflow_irq), 16'h0000);
      wr(REG_STATUS_CONTROL, 8'h80 | ctl(1'b1, CLK_EXT, 0));
      #1 check(16'(overflow_irq), 16'h0000);
      // one byte pending, then buffered update
      wr(REG_WRAP_HIGH, 8'h00);
      edges(m + 1);
      check(count_value, after(m + 1, m));
      check(16'(overflow_irq), 16'h0000);
      // buffered top lands on the old top-1 step, so a longer one extends that period
      m2 = m + 4;
      wr(REG_COUNT_LOW, 8'h00);
      wr(REG_WRAP_LOW, 8'(m2));
      edges(m2 + 1);
      check(count_value, after(m2 + 1, m2));
      check(16'(overflow_irq), 16'h0001);
      rc(REG_STATUS_CONTROL, 8'h80 | ctl(1'b1, CLK_EXT, 0));
      wr(REG_STATUS_CONTROL, ctl(1'b1, CLK_EXT, 0));
      // debug freeze and direct modulo write
      edges(2);
      rc(REG_COUNT_HIGH, 8'h00);
      edges(1);
      background_debug_mode <= 1'b1;
      edges(3);
      check(count_value, 16'h0003);
      rc(REG_COUNT_LOW, 8'h02);
      wr(REG_WRAP_LOW, 8'(m2 + 2));
      background_debug_mode <= 1'b0;
      rc(REG_COUNT_LOW, 8'h02);
      wr(REG_COUNT_LOW, 8'h00);
      edges(m2 + 3);
      check(count_value, after(m2 + 3, m2 + 2));
      check(16'(overflow_irq), 16'h0001);
      complete_run();
   end
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule
